// >>> logic/pmc_power_mode_control.sv
// pmc_power_mode_control: idle and power-down control with pin states
//
// Behaviour
// - control register at 87H, byte access only
// - power-down bit write is last instruction
// - power-down entered only by software bit
// - oscillator stops, state kept, pins show latches
// - both strobes low in power-down
// - interrupt wake waits 1536 oscillator periods
// - reset wake: 24 periods, no settling delay
// - idle bit write is last instruction
// - idle gates only the cpu clock
// - idle keeps state, freezes pins, strobes high
// - enabled interrupt clears mode bits, ends idle
// - two general flags writable with idle bit
// - hardware reset ends idle, two machine cycles
// - reset restores registers, not ram
// - power-down keeps high address latch, pulled up in external memory mode
// - external memory pin states in low power
// - bit 7 is baud double, 4..6 reserved
// - machine cycle is 12 oscillator periods
// - baud double bit is zero after reset
`timescale 1ns/100ps
module pmc_power_mode_control
	import pmc_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [7:0] sfr_addr,
	input wire logic [7:0] sfr_wdata,
	input wire logic sfr_wr,
	input wire logic sfr_rd,
	input wire logic sfr_bit_access,
	output logic [7:0] sfr_rdata,
	output logic sfr_hit,
	input wire logic irq_pending,
	input wire logic [7:0] wake_interrupt_lines,
	input wire logic [7:0] wake_enable,
	input wire logic ext_mem_mode,
	input wire logic [7:0] core_port0_out,
	input wire logic [7:0] core_port0_oe_n,
	input wire logic [7:0] core_port1_out,
	input wire logic [7:0] core_port2_out,
	input wire logic [7:0] core_port3_out,
	input wire logic core_ale,
	input wire logic core_program_fetch_strobe,
	input wire logic [7:0] port0_latch,
	input wire logic [7:0] port1_latch,
	input wire logic [7:0] high_address_port_latch,
	input wire logic [7:0] port3_latch,
	output logic [7:0] pin_port0_out,
	output logic [7:0] pin_port0_oe_n,
	output logic [7:0] pin_port1_out,
	output logic [7:0] pin_port2_out,
	output logic [7:0] pin_port2_strong_pu,
	output logic [7:0] pin_port3_out,
	output logic address_latch_strobe,
	output logic program_fetch_strobe,
	output logic cpu_clk_en,
	output logic periph_clk_en,
	output logic osc_enable,
	output logic sfr_reset,
	output logic baud_double_bit,
	output logic general_flag_zero,
	output logic general_flag_one,
	output logic [1:0] power_mode
);

	// *****************************************
	// declarations
	// *****************************************
	pmc_mode_t mode_reg;
	pmc_mode_t mode_next;
	logic [7:0] ctrl_reg;
	logic [7:0] rdata_reg;
	logic sfr_reset_reg;
	logic ctrl_hit;
	logic ctrl_wr;
	logic wake_req;
	logic mode_clear;
	logic enter_idle;
	logic [7:0] frz_port0_reg;
	logic [7:0] frz_port0_oe_n_reg;
	logic [7:0] frz_port1_reg;
	logic [7:0] frz_port2_reg;
	logic [7:0] frz_port3_reg;
	logic [7:0] port0_reg;
	logic [7:0] port0_oe_n_reg;
	logic [7:0] port1_reg;
	logic [7:0] port2_reg;
	logic [7:0] port2_pu_reg;
	logic [7:0] port3_reg;
	logic ale_reg;
	logic program_fetch_strobe_reg;
	logic cpu_clk_en_reg;
	logic periph_clk_en_reg;
	logic osc_enable_reg;
	logic [PMC_CNT_W-1:0] settle_seen_reg;

	pmc_settle_if settle ();

	pmc_settle_timer u_settle (
		.clk(clk),
		.sys_rst(sys_rst),
		.st(settle.timer)
	);

	// *****************************************
	// register decode
	// *****************************************
	// bit-addressed accesses do not reach this register
	assign ctrl_hit = (sfr_addr == PMC_CTRL_ADDR) && !sfr_bit_access;
	assign ctrl_wr = ctrl_hit && sfr_wr && (mode_reg == PMC_RUN);
	assign sfr_hit = ctrl_hit;
	assign wake_req = |(wake_interrupt_lines & wake_enable);
	assign enter_idle = (mode_reg == PMC_RUN) && (mode_next == PMC_IDLE);
	// mode bits dropped by hardware when idle or power-down ends
	assign mode_clear = ((mode_reg == PMC_IDLE) && irq_pending) || settle.done;

	// *****************************************
	// power control register
	// *****************************************
	// reset clears every field; reserved bits always hold zero
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			ctrl_reg <= PMC_CTRL_RESET;
		end else if (ctrl_wr) begin
			ctrl_reg <= sfr_wdata & PMC_CTRL_WMASK;
		end else if (mode_clear) begin
			ctrl_reg[PMC_IDLE_BIT] <= 1'b0;
			ctrl_reg[PMC_PDOWN_BIT] <= 1'b0;
		end
	end

	// read data comes one cycle after the read strobe
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rdata_reg <= 8'h00;
		end else if (ctrl_hit && sfr_rd) begin
			rdata_reg <= ctrl_reg;
		end
	end

	// reset request for the other function registers; ram is left alone
	always_ff @(posedge clk) begin
		sfr_reset_reg <= sys_rst;
	end

	assign sfr_rdata = rdata_reg;
	assign sfr_reset = sfr_reset_reg;
	assign baud_double_bit = ctrl_reg[PMC_BAUD_BIT];
	assign general_flag_zero = ctrl_reg[PMC_FLAG0_BIT];
	assign general_flag_one = ctrl_reg[PMC_FLAG1_BIT];

	// *****************************************
	// mode state machine
	// *****************************************
	// power-down wins when both request bits arrive together
	always_comb begin
		mode_next = mode_reg;
		case (mode_reg)
			PMC_RUN: begin
				if (ctrl_wr && sfr_wdata[PMC_PDOWN_BIT]) begin
					mode_next = PMC_PDOWN;
				end else if (ctrl_wr && sfr_wdata[PMC_IDLE_BIT]) begin
					mode_next = PMC_IDLE;
				end
			end
			PMC_IDLE: begin
				if (irq_pending) begin
					mode_next = PMC_RUN;
				end
			end
			PMC_PDOWN: begin
				if (wake_req) begin
					mode_next = PMC_SETTLE;
				end
			end
			PMC_SETTLE: begin
				if (settle.done) begin
					mode_next = PMC_RUN;
				end
			end
			default: begin
				mode_next = PMC_RUN;
			end
		endcase
	end

	// reset leaves any mode at once without a settling delay
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			mode_reg <= PMC_RUN;
		end else begin
			mode_reg <= mode_next;
		end
	end

	assign settle.start = (mode_reg == PMC_PDOWN) && wake_req;
	assign power_mode = mode_reg;

	// *****************************************
	// clock gating
	// *****************************************
	// cpu stops the edge after the request write; peripherals run in idle
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			cpu_clk_en_reg <= 1'b1;
			periph_clk_en_reg <= 1'b1;
			osc_enable_reg <= 1'b1;
		end else begin
			cpu_clk_en_reg <= (mode_next == PMC_RUN);
			periph_clk_en_reg <= (mode_next == PMC_RUN) || (mode_next == PMC_IDLE);
			osc_enable_reg <= (mode_next != PMC_PDOWN);
		end
	end

	assign cpu_clk_en = cpu_clk_en_reg;
	assign periph_clk_en = periph_clk_en_reg;
	assign osc_enable = osc_enable_reg;

	// *****************************************
	// pin freeze at idle entry
	// *****************************************
	// pins keep the values they showed when idle began
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			frz_port0_reg <= 8'h00;
			frz_port0_oe_n_reg <= 8'hff;
			frz_port1_reg <= 8'hff;
			frz_port2_reg <= 8'hff;
			frz_port3_reg <= 8'hff;
		end else if (enter_idle) begin
			frz_port0_reg <= core_port0_out;
			frz_port0_oe_n_reg <= core_port0_oe_n;
			frz_port1_reg <= core_port1_out;
			frz_port2_reg <= core_port2_out;
			frz_port3_reg <= core_port3_out;
		end
	end

	// *****************************************
	// pin and strobe outputs
	// *****************************************
	// registered pin states per mode and memory kind
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			port0_reg <= 8'h00;
			port0_oe_n_reg <= 8'hff;
			port1_reg <= 8'hff;
			port2_reg <= 8'hff;
			port2_pu_reg <= 8'h00;
			port3_reg <= 8'hff;
			ale_reg <= 1'b1;
			program_fetch_strobe_reg <= 1'b1;
		end else begin
			case (mode_reg)
				PMC_IDLE: begin
					port0_reg <= frz_port0_reg;
					port0_oe_n_reg <= ext_mem_mode ? 8'hff : frz_port0_oe_n_reg;
					port1_reg <= frz_port1_reg;
					port2_reg <= frz_port2_reg;
					port2_pu_reg <= 8'h00;
					port3_reg <= frz_port3_reg;
					ale_reg <= 1'b1;
					program_fetch_strobe_reg <= 1'b1;
				end
				PMC_PDOWN, PMC_SETTLE: begin
					port0_reg <= port0_latch;
					port0_oe_n_reg <= ext_mem_mode ? 8'hff : port0_latch;
					port1_reg <= port1_latch;
					port2_reg <= high_address_port_latch;
					port2_pu_reg <= ext_mem_mode ? high_address_port_latch : 8'h00;
					port3_reg <= port3_latch;
					ale_reg <= 1'b0;
					program_fetch_strobe_reg <= 1'b0;
				end
				default: begin
					port0_reg <= core_port0_out;
					port0_oe_n_reg <= core_port0_oe_n;
					port1_reg <= core_port1_out;
					port2_reg <= core_port2_out;
					port2_pu_reg <= 8'h00;
					port3_reg <= core_port3_out;
					ale_reg <= core_ale;
					program_fetch_strobe_reg <= core_program_fetch_strobe;
				end
			endcase
		end
	end

	assign pin_port0_out = port0_reg;
	assign pin_port0_oe_n = port0_oe_n_reg;
	assign pin_port1_out = port1_reg;
	assign pin_port2_out = port2_reg;
	assign pin_port2_strong_pu = port2_pu_reg;
	assign pin_port3_out = port3_reg;
	assign address_latch_strobe = ale_reg;
	assign program_fetch_strobe = program_fetch_strobe_reg;

	// *****************************************
	// checks
	// *****************************************
	// counts settling cycles so the delay can be checked on exit
	always_ff @(posedge clk) begin
		if (sys_rst || (mode_reg != PMC_SETTLE)) begin
			settle_seen_reg <= '0;
		end else begin
			settle_seen_reg <= settle_seen_reg + 1'b1;
		end
	end

	sequence s_pdown_write;
		ctrl_wr && sfr_wdata[PMC_PDOWN_BIT];
	endsequence

	sequence s_settle_exit;
		(mode_reg == PMC_SETTLE) ##1 (mode_reg == PMC_RUN);
	endsequence

	property p_byte_only;
		@(posedge clk) disable iff (sys_rst)
		(sfr_wr && sfr_bit_access && !mode_clear) |=> $stable(ctrl_reg);
	endproperty
	a_byte_only: assert property (p_byte_only) else $error("bit access changed register");

	property p_pdown_entry;
		@(posedge clk) disable iff (sys_rst)
		s_pdown_write |=> (mode_reg == PMC_PDOWN) && !cpu_clk_en && !osc_enable;
	endproperty
	a_pdown_entry: assert property (p_pdown_entry) else $error("power-down not entered");

	property p_pdown_only_sw;
		@(posedge clk) disable iff (sys_rst)
		((mode_reg != PMC_PDOWN) && !(ctrl_wr && sfr_wdata[PMC_PDOWN_BIT]))
			|=> (mode_reg != PMC_PDOWN);
	endproperty
	a_pdown_only_sw: assert property (p_pdown_only_sw) else $error("power-down without request");

	property p_pdown_strobes;
		@(posedge clk) disable iff (sys_rst)
		(mode_reg == PMC_PDOWN) |=> !address_latch_strobe && !program_fetch_strobe;
	endproperty
	a_pdown_strobes: assert property (p_pdown_strobes) else $error("strobes not low");

	property p_settle_len;
		@(posedge clk) disable iff (sys_rst)
		s_settle_exit |-> (settle_seen_reg == PMC_CNT_W'(PMC_SETTLE_CYCLES));
	endproperty
	a_settle_len: assert property (p_settle_len) else $error("settling delay wrong");

	property p_reset_wake;
		@(posedge clk)
		sys_rst |=> (mode_reg == PMC_RUN) && !settle.busy && cpu_clk_en;
	endproperty
	a_reset_wake: assert property (p_reset_wake) else $error("reset did not wake");

	property p_idle_pins;
		@(posedge clk) disable iff (sys_rst)
		(mode_reg == PMC_IDLE) |=> address_latch_strobe && program_fetch_strobe
			&& (cpu_clk_en == $past(irq_pending)) && periph_clk_en;
	endproperty
	a_idle_pins: assert property (p_idle_pins) else $error("idle pin state wrong");

	property p_idle_exit;
		@(posedge clk) disable iff (sys_rst)
		((mode_reg == PMC_IDLE) && irq_pending) |=> (mode_reg == PMC_RUN)
			&& !ctrl_reg[PMC_IDLE_BIT] && $stable(ctrl_reg[PMC_FLAG1_BIT:PMC_FLAG0_BIT]);
	endproperty
	a_idle_exit: assert property (p_idle_exit) else $error("idle not ended");

	property p_baud_reset;
		@(posedge clk)
		sys_rst |=> !baud_double_bit && sfr_reset;
	endproperty
	a_baud_reset: assert property (p_baud_reset) else $error("reset values wrong");

endmodule

// >>> logic/pmc_pkg.sv
// pmc_pkg: constants and types of the power mode control block
package pmc_pkg;

	// *****************************************
	// register map
	// *****************************************
	localparam logic [7:0] PMC_CTRL_ADDR = 8'h87; // power control register address
	localparam logic [7:0] PMC_CTRL_RESET = 8'h00; // value after reset
	localparam logic [7:0] PMC_CTRL_WMASK = 8'h8f; // reserved bits 4..6 hold zero

	// *****************************************
	// field positions
	// *****************************************
	localparam int PMC_IDLE_BIT = 0;
	localparam int PMC_PDOWN_BIT = 1;
	localparam int PMC_FLAG0_BIT = 2;
	localparam int PMC_FLAG1_BIT = 3;
	localparam int PMC_BAUD_BIT = 7;

	// *****************************************
	// timing
	// *****************************************
	localparam int PMC_CLK_PERIOD_NS = 100; // clk at 10 MHz
	localparam int PMC_OSC_PERIOD_NS = 100; // clk is the oscillator
	localparam int PMC_SETTLE_PERIODS = 1536; // oscillator periods after interrupt wake
	localparam int PMC_SETTLE_CYCLES =
		(PMC_SETTLE_PERIODS * PMC_OSC_PERIOD_NS) / PMC_CLK_PERIOD_NS;
	localparam int PMC_MACHINE_PERIODS = 12; // oscillator periods per machine cycle
	localparam int PMC_PDOWN_RST_PERIODS = 24; // least reset length to leave power-down
	localparam int PMC_IDLE_RST_MCYCLES = 2; // least reset length to leave idle
	localparam int PMC_CNT_W = 11;

	// *****************************************
	// mode state
	// *****************************************
	typedef enum logic [1:0] {
		PMC_RUN = 2'b00,
		PMC_IDLE = 2'b01,
		PMC_PDOWN = 2'b10,
		PMC_SETTLE = 2'b11
	} pmc_mode_t;

endpackage

// >>> logic/pmc_settle_if.sv
// pmc_settle_if: handshake between mode control and the settling counter
`timescale 1ns/100ps
interface pmc_settle_if;
	logic start; // one-cycle pulse: begin settling delay
	logic busy; // level: delay running
	logic done; // one-cycle pulse: last delay cycle
	modport ctrl (output start, input busy, input done);
	modport timer (input start, output busy, output done);
endinterface

// >>> logic/pmc_settle_timer.sv
// pmc_settle_timer: oscillator settling delay counter used on interrupt wake
`timescale 1ns/100ps
module pmc_settle_timer
	import pmc_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	pmc_settle_if.timer st
);

	logic [PMC_CNT_W-1:0] cnt_reg;
	logic busy_reg;

	// *****************************************
	// down counter
	// *****************************************
	// reset stops the counter, so a reset wake never runs it
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			cnt_reg <= '0;
			busy_reg <= 1'b0;
		end else if (st.start && !busy_reg) begin
			cnt_reg <= PMC_CNT_W'(PMC_SETTLE_CYCLES - 1);
			busy_reg <= 1'b1;
		end else if (busy_reg) begin
			cnt_reg <= cnt_reg - 1'b1;
			if (cnt_reg == '0) begin
				busy_reg <= 1'b0;
			end
		end
	end

	assign st.busy = busy_reg;
	assign st.done = busy_reg && (cnt_reg == '0);

endmodule

// >>> verif/pmc_core_model.sv
// pmc_core_model: cpu core and reset source facing the power mode block
`timescale 1ns/100ps
module pmc_core_model
	import pmc_pkg::*;
(
	input wire logic clk,
	input wire logic hold,
	input wire logic rst_req,
	output logic sys_rst,
	output logic [7:0] core_port0_out,
	output logic [7:0] core_port0_oe_n,
	output logic [7:0] core_port1_out,
	output logic [7:0] core_port2_out,
	output logic [7:0] core_port3_out,
	output logic core_ale,
	output logic core_program_fetch_strobe
);
	int rst_cnt = 10;
	logic hold_q = 1'h0;

	// reset source: two machine cycles, long enough for the oscillator to restart
	always @(posedge clk) begin
		hold_q <= hold;
		if (rst_req) begin
			rst_cnt <= 2 * PMC_MACHINE_PERIODS;
		end else if (rst_cnt > 0) begin
			rst_cnt <= rst_cnt - 1;
		end
	end

	// time-zero values, reset asserted
	initial begin
		sys_rst = 1'h1;
		{core_port0_out, core_port0_oe_n, core_port1_out, core_port2_out} = 32'h00000000;
		{core_port3_out, core_ale, core_program_fetch_strobe} = 10'h000;
	end

	// core pins change every cycle unless held; a held core keeps its pins and parks its strobes low
	always @(negedge clk) begin
		sys_rst <= (rst_cnt != 0);
		if (!hold_q) begin
			{core_port0_out, core_port0_oe_n, core_port1_out, core_port2_out} <= $urandom;
			{core_port3_out, core_ale, core_program_fetch_strobe} <= 10'($urandom);
		end else begin
			{core_ale, core_program_fetch_strobe} <= 2'h0;
		end
	end
endmodule

// >>> verif/power_mode_control_bench.sv
// power_mode_control_bench: self-checking bench of the power mode block
`timescale 1ns/100ps
module power_mode_control_bench;
	import pmc_pkg::*;
	logic clk = 1'h0;
	logic hold = 1'h0;
	logic rst_req = 1'h0;
	logic sfr_wr = 1'h0;
	logic sfr_rd = 1'h0;
	logic sfr_bit_access = 1'h0;
	logic irq_pending = 1'h0;
	logic ext_mem_mode = 1'h0;
	logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, wake_interrupt_lines = 8'h00;
	logic [7:0] wake_enable = 8'h00, port0_latch = 8'h00, port1_latch = 8'h00;
	logic [7:0] high_address_port_latch = 8'h00, port3_latch = 8'h00;
	logic sys_rst, core_ale, core_program_fetch_strobe, address_latch_strobe, program_fetch_strobe;
	logic cpu_clk_en, periph_clk_en, osc_enable, baud_double_bit;
	logic general_flag_zero, general_flag_one;
	logic [1:0] power_mode;
	logic sfr_hit, sfr_reset;
	logic [7:0] core_port0_out, core_port0_oe_n, core_port1_out, core_port2_out;
	logic [7:0] core_port3_out, sfr_rdata, pin_port0_out, pin_port0_oe_n, pin_port1_out;
	logic [7:0] pin_port2_out, pin_port2_strong_pu, pin_port3_out;
	int mismatches = 0;
	int cmp_count = 0;
	int cyc = 0;
	int n;
	logic [7:0] exp_q[$];
	logic rd_p1 = 1'h0;
	logic rd_p2 = 1'h0;
	logic [7:0] cap[4];

	// ************************************
	// clock, partner and design
	// ************************************
	always #(PMC_CLK_PERIOD_NS / 2) clk = ~clk;

	pmc_core_model partner (.clk, .hold, .rst_req, .sys_rst, .core_port0_out,
		.core_port0_oe_n, .core_port1_out, .core_port2_out, .core_port3_out, .core_ale,
		.core_program_fetch_strobe);

	pmc_power_mode_control DUT (.clk, .sys_rst, .sfr_addr, .sfr_wdata, .sfr_wr, .sfr_rd,
		.sfr_bit_access, .sfr_rdata, .sfr_hit, .irq_pending, .wake_interrupt_lines,
		.wake_enable, .ext_mem_mode, .core_port0_out, .core_port0_oe_n, .core_port1_out,
		.core_port2_out, .core_port3_out, .core_ale, .core_program_fetch_strobe, .port0_latch, .port1_latch,
		.high_address_port_latch, .port3_latch, .pin_port0_out, .pin_port0_oe_n,
		.pin_port1_out, .pin_port2_out, .pin_port2_strong_pu, .pin_port3_out,
		.address_latch_strobe, .program_fetch_strobe, .cpu_clk_en, .periph_clk_en,
		.osc_enable, .sfr_reset, .baud_double_bit, .general_flag_zero, .general_flag_one,
		.power_mode);

	// ************************************
	// checking and bus tasks
	// ************************************
	task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic finish_test();
		$display("mismatches %0d comparisons %0d", mismatches, cmp_count);
		if (mismatches == 0 && cmp_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic wr(logic [7:0] a, logic [7:0] d, logic b);
		@(negedge clk);
		sfr_addr = a;
		sfr_wdata = d;
		sfr_bit_access = b;
		sfr_wr = 1'h1;
		@(negedge clk);
		sfr_wr = 1'h0;
		sfr_bit_access = 1'h0;
	endtask

	// read notes its expected value, the monitor compares it
	task automatic rd(logic [7:0] e);
		@(negedge clk);
		sfr_addr = PMC_CTRL_ADDR;
		exp_q.push_back(e);
		sfr_rd = 1'h1;
		@(negedge clk);
		sfr_rd = 1'h0;
		repeat (2) @(negedge clk);
	endtask

	task automatic mode(logic [1:0] m);
		check("power mode", {14'h0000, power_mode}, {14'h0000, m});
	endtask

	// reset pulse from the partner, then wait for its release
	task automatic rst_pulse();
		rst_req = 1'h1;
		@(negedge clk);
		rst_req = 1'h0;
		@(negedge clk);
		check("sfr reset", sfr_reset, 16'h0001);
		n = 0;
		while (sys_rst !== 1'h0 && n < 100) begin
			n++;
			@(negedge clk);
		end
		@(negedge clk);
	endtask

	// read monitor and hang guard
	always @(posedge clk) begin
		rd_p1 <= sfr_rd;
		rd_p2 <= rd_p1;
		cyc++;
		if (cyc == 12000) begin
			mismatches++;
			finish_test();
		end
	end
	always @(negedge clk) begin
		if (rd_p2) begin
			check("read data", sfr_rdata, exp_q.pop_front());
		end
	end

	// ************************************
	// main sequence
	// ************************************
	initial begin
		void'($urandom(32'hb246));
		{port0_latch, port1_latch, high_address_port_latch, port3_latch} = $urandom;
		repeat (12) @(negedge clk);
		rd(8'h00);
		check("baud", baud_double_bit, 16'h0000);
		check("sfr reset", sfr_reset, 16'h0000);
		// stray traffic elsewhere never enters a low power mode
		repeat (16) begin
			n = $urandom;
			irq_pending = n[8];
			wake_interrupt_lines = n[23:16];
			wake_enable = n[31:24];
			wr((n[7:0] == PMC_CTRL_ADDR) ? 8'h86 : n[7:0], 8'h03, 1'h0);
		end
		check("hit", sfr_hit, 16'h0000);
		wr(PMC_CTRL_ADDR, 8'h03, 1'h1);
		@(negedge clk);
		mode(PMC_RUN);
		check("hit", sfr_hit, 16'h0001);
		{irq_pending, wake_interrupt_lines, wake_enable} = 17'h00000;
		wr(PMC_CTRL_ADDR, 8'hfc, 1'h0);
		rd(8'h8c);
		// idle with flags and baud bit in the same write
		hold = 1'h1;
		wr(PMC_CTRL_ADDR, 8'h8d, 1'h0);
		repeat (2) @(negedge clk);
		cap = '{core_port0_out, core_port1_out, core_port2_out, core_port3_out};
		mode(PMC_IDLE);
		check("cpu clock", cpu_clk_en, 16'h0000);
		check("periph clock", periph_clk_en, 16'h0001);
		check("strobes", {address_latch_strobe, program_fetch_strobe}, 16'h0003);
		check("baud", baud_double_bit, 16'h0001);
		hold = 1'h0;
		repeat (4) @(negedge clk);
		check("port0 idle", pin_port0_out, cap[0]);
		check("port1 idle", pin_port1_out, cap[1]);
		check("port2 idle", pin_port2_out, cap[2]);
		check("port3 idle", pin_port3_out, cap[3]);
		irq_pending = 1'h1;
		@(negedge clk);
		irq_pending = 1'h0;
		@(negedge clk);
		mode(PMC_RUN);
		check("cpu clock", cpu_clk_en, 16'h0001);
		check("flags", {general_flag_one, general_flag_zero}, 16'h0003);
		rd(8'h8c);
		// power-down from external memory, both bits set
		ext_mem_mode = 1'h1;
		wr(PMC_CTRL_ADDR, 8'h83, 1'h0);
		repeat (2) @(negedge clk);
		mode(PMC_PDOWN);
		check("cpu clock", cpu_clk_en, 16'h0000);
		check("osc", osc_enable, 16'h0000);
		check("periph clock", periph_clk_en, 16'h0000);
		check("strobes", {address_latch_strobe, program_fetch_strobe}, 16'h0000);
		check("port0 float", pin_port0_oe_n, 16'h00ff);
		check("port1 pd", pin_port1_out, port1_latch);
		check("port2 pd", pin_port2_out, high_address_port_latch);
		check("port2 pull-up", pin_port2_strong_pu, high_address_port_latch);
		check("port3 pd", pin_port3_out, port3_latch);
		wake_enable = 8'h04;
		wake_interrupt_lines = 8'h04;
		@(negedge clk);
		wake_interrupt_lines = 8'h00;
		n = 0;
		while (power_mode === PMC_SETTLE && n < 2000) begin
			n++;
			@(negedge clk);
		end
		check("settle cycles", n[15:0], 16'(PMC_SETTLE_PERIODS));
		mode(PMC_RUN);
		check("cpu clock", cpu_clk_en, 16'h0001);
		rd(8'h80);
		// internal power-down: disabled lines stay asleep, reset wakes at once
		ext_mem_mode = 1'h0;
		wr(PMC_CTRL_ADDR, 8'h02, 1'h0);
		wake_enable = 8'h00;
		wake_interrupt_lines = 8'hff;
		repeat (3) @(negedge clk);
		mode(PMC_PDOWN);
		check("port0 pd", pin_port0_out, port0_latch);
		rst_pulse();
		wake_interrupt_lines = 8'h00;
		mode(PMC_RUN);
		rd(8'h00);
		// idle from external memory, a refused write, then hardware reset
		ext_mem_mode = 1'h1;
		wr(PMC_CTRL_ADDR, 8'h01, 1'h0);
		repeat (2) @(negedge clk);
		mode(PMC_IDLE);
		check("port0 float", pin_port0_oe_n, 16'h00ff);
		wr(PMC_CTRL_ADDR, 8'h02, 1'h0);
		@(negedge clk);
		mode(PMC_IDLE);
		rst_pulse();
		mode(PMC_RUN);
		check("cpu clock", cpu_clk_en, 16'h0001);
		rd(8'h00);
		finish_test();
	end
endmodule
